// File: src/motor_pwm_defs.vh
`ifndef MOTOR_PWM_DEFS_VH
`define MOTOR_PWM_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_MODE_CONTROL 6'h00
`define OFS_RUN_CONTROL 6'h04
`define OFS_COUNT_STATUS 6'h08
`define OFS_CARRIER_COUNT 6'h0C
`define OFS_PERIOD 6'h10
`define OFS_CMP_U 6'h14
`define OFS_CMP_V 6'h18
`define OFS_CMP_W 6'h1C
`define OFS_ENG_U 6'h20
`define OFS_ENG_V 6'h24
`define OFS_ENG_W 6'h28
`define OFS_IRQ_STATUS 6'h2C
`define OFS_IRQ_MASK 6'h30

// ****************************************
// mode control fields
// ****************************************
`define MC_SHAPE 0
`define MC_CYCLE_LO 1
`define MC_CYCLE_HI 2
`define MC_TIMING 3
`define MC_DUTY 4
`define MC_SYNC_LO 8
`define MC_SYNC_HI 9
`define MC_EDGE_U_HI 11
`define MC_EDGE_V_HI 13
`define MC_EDGE_W_HI 15
`define MC_WRITE_MASK 16'hFF7F
`define MC_RESET 16'h0000

// ****************************************
// run control fields
// ****************************************
`define RC_RUN 0
`define RC_LINK 1
`define RC_SWITCH 2
`define RC_WIDTH 3

// ****************************************
// encodings and constants
// ****************************************
`define CYCLE_HALF 2'h0
`define CYCLE_ONE 2'h1
`define CYCLE_TWO 2'h2
`define SYNC_AUTO 2'h0
`define SYNC_BOTTOM 2'h1
`define SYNC_PEAK 2'h2
`define SYNC_BOTH 2'h3
`define CARRIER_BOTTOM 16'h0001
`define IRQ_BIT_PWM 0
`define IRQ_BIT_LOAD 1
`define IRQ_WIDTH 2

`endif

// File: src/carrier_counter.v
`include "motor_pwm_defs.vh"

// ****************************************
// up-down carrier counter
// ****************************************
module carrier_counter #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire run,
  input wire triangular,
  input wire [WIDTH-1:0] period,
  output reg [WIDTH-1:0] count_q,
  output reg down_q
);

  localparam [WIDTH-1:0] BOTTOM = `CARRIER_BOTTOM;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= BOTTOM;
      down_q <= 1'b0;
    end else if (!run) begin
      // idle value depends on carrier shape
      count_q <= triangular ? period : BOTTOM;
      down_q <= 1'b0;
    end else if (!triangular) begin
      down_q <= 1'b0;
      if (count_q >= period) begin
        count_q <= BOTTOM;
      end else begin
        count_q <= count_q + BOTTOM;
      end
    end else if (down_q) begin
      // turn around at the bottom
      if (count_q <= BOTTOM) begin
        down_q <= 1'b0;
        count_q <= count_q + BOTTOM;
      end else begin
        count_q <= count_q - BOTTOM;
      end
    end else begin
      // turn around at the peak
      if (count_q >= period) begin
        down_q <= 1'b1;
        count_q <= count_q - BOTTOM;
      end else begin
        count_q <= count_q + BOTTOM;
      end
    end
  end

endmodule // carrier_counter

// File: src/motor_pwm_carrier_control.v
// What this block does
// - duty mode 0 shares U compare on all phases; 1 uses own registers.
// - timing bit 0 fires at bottom (count 0x0001); 1 fires at peak.
// - sawtooth carrier always fires interrupt at peak.
// - cycle field 00 fires at both peak and bottom.
// - cycle field 00/01/10/11 gives half, one, two, four periods.
// - cycle field only matters with triangular carrier.
// - shape 0 sawtooth edge-aligned; shape 1 triangular center-aligned.
// - update timing 00 loads at both if cycle 00, else at peak.
// - update timing 01 bottom, 10 peak, 11 both.
// - timing 11 or 00/00: edge bit1 0 own up, engine down; else engine.
// - source switching only when link, switch enable and shape all 1.
// - sawtooth carrier loads buffers at peak whatever update timing.
// - while run enable is 0, buffered registers update on write.
// - edge setting 00 unfixed, 01 reserved, 10 rise, 11 fall at bottom.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`include "motor_pwm_defs.vh"

module motor_pwm_carrier_control #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg irq,
  output reg pwm_irq_req,
  output reg [WIDTH-1:0] carrier_count,
  output reg count_down,
  output reg [WIDTH-1:0] phase_u_level,
  output reg [WIDTH-1:0] phase_v_level,
  output reg [WIDTH-1:0] phase_w_level
);

  // ****************************************
  // state
  // ****************************************
  reg [15:0] mode_q;
  reg [`RC_WIDTH-1:0] run_ctl_q;
  reg [WIDTH-1:0] prd_buf_q;
  reg [WIDTH-1:0] prd_q;
  reg [WIDTH-1:0] cmp_buf_q [0:2];
  reg [WIDTH-1:0] cmp_q [0:2];
  reg [WIDTH-1:0] eng_buf_q [0:2];
  reg [WIDTH-1:0] eng_q [0:2];
  reg [`IRQ_WIDTH-1:0] irq_stat_q;
  reg [`IRQ_WIDTH-1:0] irq_mask_q;
  reg [1:0] period_cnt_q;
  reg [31:0] rd_d;
  reg [`IRQ_WIDTH-1:0] irq_stat_d;
  wire [WIDTH-1:0] cnt;
  wire down;
  integer i;

  wire run = run_ctl_q[`RC_RUN];
  wire tri_mode = mode_q[`MC_SHAPE];
  wire [1:0] cycle = mode_q[`MC_CYCLE_HI:`MC_CYCLE_LO];
  wire [1:0] sync = mode_q[`MC_SYNC_HI:`MC_SYNC_LO];
  wire do_write = write && !waitrequest;
  wire do_read = read && !waitrequest;

  // ****************************************
  // carrier counter
  // ****************************************
  carrier_counter #(
    .WIDTH(WIDTH)
  ) u_counter (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(run),
    .triangular(tri_mode),
    .period(prd_q),
    .count_q(cnt),
    .down_q(down)
  );

  wire at_peak = run && (cnt == prd_q);
  wire at_bottom = run && tri_mode && (cnt == `CARRIER_BOTTOM);

  // ****************************************
  // interrupt request timing
  // ****************************************
  wire half_cycle = tri_mode && (cycle == `CYCLE_HALF);
  wire sel_event = mode_q[`MC_TIMING] ? at_peak : at_bottom;
  reg fire;

  always @* begin
    fire = 1'b0;
    if (!tri_mode) begin
      fire = at_peak;
    end else if (cycle == `CYCLE_HALF) begin
      fire = at_peak || at_bottom;
    end else if (cycle == `CYCLE_ONE) begin
      fire = sel_event;
    end else if (cycle == `CYCLE_TWO) begin
      fire = sel_event && (period_cnt_q[0] == 1'b0);
    end else begin
      fire = sel_event && (period_cnt_q == 2'h0);
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_cnt_q <= 2'h0;
    end else if (!run || !tri_mode) begin
      period_cnt_q <= 2'h0;
    end else if (sel_event) begin
      period_cnt_q <= period_cnt_q + 2'h1;
    end
  end

  // ****************************************
  // double buffer load timing
  // ****************************************
  reg load;

  always @* begin
    load = 1'b0;
    if (!tri_mode) begin
      load = at_peak;
    end else if (sync == `SYNC_AUTO) begin
      load = half_cycle ? (at_peak || at_bottom) : at_peak;
    end else if (sync == `SYNC_BOTTOM) begin
      load = at_bottom;
    end else if (sync == `SYNC_PEAK) begin
      load = at_peak;
    end else begin
      load = at_peak || at_bottom;
    end
  end

  // ****************************************
  // compare source selection
  // ****************************************
  wire switch_ok = run_ctl_q[`RC_LINK] && run_ctl_q[`RC_SWITCH] &&
    tri_mode;
  wire split_sync = (sync == `SYNC_BOTH) ||
    ((sync == `SYNC_AUTO) && (cycle == `CYCLE_HALF));

  // edge bit1 set means edge fixed to bottom (10/11)
  function [WIDTH-1:0] pick;
    input [WIDTH-1:0] own;
    input [WIDTH-1:0] eng;
    input edge_hi;
    begin
      if (!switch_ok) begin
        pick = own;
      end else if (split_sync && !edge_hi && !down) begin
        pick = own;
      end else begin
        pick = eng;
      end
    end
  endfunction

  // shared U compare in common duty mode
  wire duty_ind = mode_q[`MC_DUTY];
  wire [WIDTH-1:0] own_v = duty_ind ? cmp_q[1] : cmp_q[0];
  wire [WIDTH-1:0] own_w = duty_ind ? cmp_q[2] : cmp_q[0];

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_u_level <= {WIDTH{1'b0}};
      phase_v_level <= {WIDTH{1'b0}};
      phase_w_level <= {WIDTH{1'b0}};
      carrier_count <= {WIDTH{1'b0}};
      count_down <= 1'b0;
      pwm_irq_req <= 1'b0;
    end else begin
      phase_u_level <= pick(cmp_q[0], eng_q[0], mode_q[`MC_EDGE_U_HI]);
      phase_v_level <= pick(own_v, eng_q[1], mode_q[`MC_EDGE_V_HI]);
      phase_w_level <= pick(own_w, eng_q[2], mode_q[`MC_EDGE_W_HI]);
      carrier_count <= cnt;
      count_down <= down && tri_mode;
      pwm_irq_req <= fire;
    end
  end

  // ****************************************
  // register writes and buffer loads
  // ****************************************
  wire wr_prd = do_write && (address == `OFS_PERIOD);

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= `MC_RESET;
      run_ctl_q <= {`RC_WIDTH{1'b0}};
      irq_mask_q <= {`IRQ_WIDTH{1'b0}};
      prd_buf_q <= {WIDTH{1'b0}};
      prd_q <= {WIDTH{1'b0}};
      for (i = 0; i < 3; i = i + 1) begin
        cmp_buf_q[i] <= {WIDTH{1'b0}};
        cmp_q[i] <= {WIDTH{1'b0}};
        eng_buf_q[i] <= {WIDTH{1'b0}};
        eng_q[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (do_write && (address == `OFS_MODE_CONTROL)) begin
        mode_q <= writedata[15:0] & `MC_WRITE_MASK;
      end
      if (do_write && (address == `OFS_RUN_CONTROL)) begin
        run_ctl_q <= writedata[`RC_WIDTH-1:0];
      end
      if (do_write && (address == `OFS_IRQ_MASK)) begin
        irq_mask_q <= writedata[`IRQ_WIDTH-1:0];
      end
      if (wr_prd) begin
        prd_buf_q <= writedata[WIDTH-1:0];
      end
      for (i = 0; i < 3; i = i + 1) begin
        if (do_write && (address == `OFS_CMP_U + 4 * i)) begin
          cmp_buf_q[i] <= writedata[WIDTH-1:0];
        end
        if (do_write && (address == `OFS_ENG_U + 4 * i)) begin
          eng_buf_q[i] <= writedata[WIDTH-1:0];
        end
      end
      if (!run) begin
        // stopped: buffers pass straight through
        prd_q <= wr_prd ? writedata[WIDTH-1:0] : prd_buf_q;
        for (i = 0; i < 3; i = i + 1) begin
          cmp_q[i] <= cmp_buf_q[i];
          eng_q[i] <= eng_buf_q[i];
        end
      end else if (load) begin
        prd_q <= prd_buf_q;
        for (i = 0; i < 3; i = i + 1) begin
          cmp_q[i] <= cmp_buf_q[i];
          eng_q[i] <= eng_buf_q[i];
        end
      end
    end
  end

  // ****************************************
  // interrupt status, read clears
  // ****************************************
  always @* begin
    irq_stat_d = irq_stat_q;
    if (do_read && (address == `OFS_IRQ_STATUS)) begin
      irq_stat_d = irq_stat_q & ~readdata[`IRQ_WIDTH-1:0];
    end
    // new events win over the clear
    if (fire) begin
      irq_stat_d[`IRQ_BIT_PWM] = 1'b1;
    end
    if (run && load) begin
      irq_stat_d[`IRQ_BIT_LOAD] = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= {`IRQ_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ****************************************
  // avalon slave: one wait state
  // ****************************************
  always @* begin
    rd_d = 32'h00000000;
    if (address == `OFS_MODE_CONTROL) begin
      rd_d[15:0] = mode_q;
    end else if (address == `OFS_RUN_CONTROL) begin
      rd_d[`RC_WIDTH-1:0] = run_ctl_q;
    end else if (address == `OFS_COUNT_STATUS) begin
      rd_d[0] = down && tri_mode;
    end else if (address == `OFS_CARRIER_COUNT) begin
      rd_d[WIDTH-1:0] = cnt;
    end else if (address == `OFS_PERIOD) begin
      rd_d[WIDTH-1:0] = prd_buf_q;
    end else if (address == `OFS_CMP_U) begin
      rd_d[WIDTH-1:0] = cmp_buf_q[0];
    end else if (address == `OFS_CMP_V) begin
      rd_d[WIDTH-1:0] = cmp_buf_q[1];
    end else if (address == `OFS_CMP_W) begin
      rd_d[WIDTH-1:0] = cmp_buf_q[2];
    end else if (address == `OFS_ENG_U) begin
      rd_d[WIDTH-1:0] = eng_buf_q[0];
    end else if (address == `OFS_ENG_V) begin
      rd_d[WIDTH-1:0] = eng_buf_q[1];
    end else if (address == `OFS_ENG_W) begin
      rd_d[WIDTH-1:0] = eng_buf_q[2];
    end else if (address == `OFS_IRQ_STATUS) begin
      rd_d[`IRQ_WIDTH-1:0] = irq_stat_q;
    end else if (address == `OFS_IRQ_MASK) begin
      rd_d[`IRQ_WIDTH-1:0] = irq_mask_q;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata <= read ? rd_d : 32'h00000000;
    end else begin
      waitrequest <= 1'b1;
    end
  end

endmodule // motor_pwm_carrier_control

// File: sim/gate_stage_model.sv
// *****
// inverter gate stage: high while carrier below level
// *****
module gate_stage_model #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [WIDTH-1:0] carrier_count,
  input wire [WIDTH-1:0] phase_u_level,
  input wire [WIDTH-1:0] phase_v_level,
  input wire [WIDTH-1:0] phase_w_level,
  output logic [2:0] gate_q
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_q <= 3'h0;
    end else begin
      gate_q[0] <= carrier_count < phase_u_level;
      gate_q[1] <= carrier_count < phase_v_level;
      gate_q[2] <= carrier_count < phase_w_level;
    end
  end
endmodule // gate_stage_model

// File: sim/pwm_ctl_properties.sv
`include "motor_pwm_defs.vh"

module pwm_ctl_checker #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire irq,
  input wire pwm_irq_req,
  input wire [WIDTH-1:0] carrier_count,
  input wire count_down,
  input wire [WIDTH-1:0] phase_u_level,
  input wire [WIDTH-1:0] phase_v_level,
  input wire [WIDTH-1:0] phase_w_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // *****
  // shadow of the control writes
  // *****
  logic [15:0] mode_q;
  logic [2:0] runc_q;
  logic [WIDTH-1:0] per_q;
  logic seen_q;
  logic [19:0] gap_q;
  wire acc = write && !waitrequest;
  wire tri_m = mode_q[0];
  wire [1:0] cyc = mode_q[2:1];
  wire run = runc_q[0];
  wire [19:0] exp_gap = tri_m ? (20'(per_q) - 20'h00001) << cyc : 20'(per_q);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= 16'h0000;
      runc_q <= 3'h0;
      per_q <= '0;
      seen_q <= 1'b0;
      gap_q <= 20'h00000;
    end else begin
      if (acc && address == `OFS_MODE_CONTROL) mode_q <= writedata[15:0];
      if (acc && address == `OFS_RUN_CONTROL) runc_q <= writedata[2:0];
      if (acc && address == `OFS_PERIOD) per_q <= writedata[WIDTH-1:0];
      seen_q <= run && (seen_q || pwm_irq_req);
      gap_q <= pwm_irq_req ? 20'h00001 : gap_q + 20'h00001;
    end
  end
  // *****
  // properties
  // *****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_bottom;
    carrier_count == 16'h0002 ##1 carrier_count == 16'h0001;
  endsequence
  sequence s_peak;
    carrier_count == per_q - 1'b1 ##1 carrier_count == per_q;
  endsequence
  property p_wait;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  property p_saw_irq;
    !tri_m && run && pwm_irq_req |=> carrier_count == 16'h0001;
  endproperty
  property p_gap;
    run && seen_q && pwm_irq_req |-> gap_q == exp_gap;
  endproperty
  property p_bottom;
    tri_m && run && cyc != 2'h0 && !mode_q[3] && pwm_irq_req
      |-> carrier_count == 16'h0001;
  endproperty
  property p_peak;
    tri_m && run && cyc != 2'h0 && mode_q[3] && pwm_irq_req
      |-> carrier_count == per_q;
  endproperty
  property p_half;
    tri_m && run && cyc == 2'h0 ##0 (s_bottom or s_peak) |-> pwm_irq_req;
  endproperty
  property p_duty;
    (!mode_q[4] && !(runc_q[1] && runc_q[2]))[*3]
      |-> phase_v_level == phase_u_level && phase_w_level == phase_u_level;
  endproperty
  property p_dir;
    (!tri_m)[*3] |-> !count_down;
  endproperty
  property p_range;
    (tri_m && run)[*2] |-> carrier_count <= per_q && carrier_count != 0;
  endproperty
  a_wait: assert property (p_wait) else $error("bad wait state");
  a_saw_irq: assert property (p_saw_irq) else $error("saw irq");
  a_gap: assert property (p_gap) else $error("irq gap");
  a_bottom: assert property (p_bottom) else $error("bottom irq");
  a_peak: assert property (p_peak) else $error("peak irq");
  a_half: assert property (p_half) else $error("half irq");
  a_duty: assert property (p_duty) else $error("common duty");
  a_dir: assert property (p_dir) else $error("saw direction");
  a_range: assert property (p_range) else $error("count range");
endmodule // pwm_ctl_checker

bind motor_pwm_carrier_control pwm_ctl_checker #(.WIDTH(WIDTH)) chk_inst (
  .ref_clk, .rst_b, .address, .read, .write, .writedata, .readdata,
  .waitrequest, .irq, .pwm_irq_req, .carrier_count, .count_down,
  .phase_u_level, .phase_v_level, .phase_w_level
);

// File: sim/test_motor_pwm_carrier_control.sv
`include "motor_pwm_defs.vh"

module test_motor_pwm_carrier_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] P = 16'h0008;
  logic ref_clk, rst_b, read, write, waitrequest, irq, pwm_irq_req;
  logic count_down;
  logic [5:0] address;
  logic [31:0] writedata, readdata, q;
  logic [15:0] carrier_count, phase_u_level, phase_v_level, phase_w_level;
  logic [15:0] m, egap, ecnt;
  logic [2:0] gate;
  logic [15:0] modes [6] = '{16'h0006, 16'h0001, 16'h0003, 16'h000B,
    16'h000D, 16'h0007};
  int miscompares, comparisons, g;
  motor_pwm_carrier_control #(.WIDTH(16)) motor_pwm_carrier_control_inst (
    .ref_clk, .rst_b, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .irq, .pwm_irq_req, .carrier_count, .count_down,
    .phase_u_level, .phase_v_level, .phase_w_level);
  gate_stage_model #(.WIDTH(16)) gate_stage_model_inst (
    .ref_clk, .rst_b, .carrier_count, .phase_u_level, .phase_v_level,
    .phase_w_level, .gate_q(gate));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // *****
  // tasks
  // *****
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string w, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic bus(input logic rd, input logic [5:0] a,
    input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic rdc(input string w, input logic [5:0] a,
    input logic [31:0] e);
    bus(1'b1, a, 32'h00000000);
    check(w, q, e);
  endtask
  task automatic wait_pulse;
    g = 0;
    do begin
      @(negedge ref_clk);
      g++;
    end while (pwm_irq_req !== 1'b1 && g < 400);
    if (g >= 400) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic wait_at(input logic dn);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(carrier_count === 16'h0004 && count_down === dn) && n < 200);
    repeat (2) @(negedge ref_clk);
    if (n >= 200) begin
      miscompares++;
      final_report();
    end
  endtask
  // *****
  // tests
  // *****
  initial begin
    rst_b = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h00000000;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc("mode reset", `OFS_MODE_CONTROL, 32'h00000000);
    rdc("run reset", `OFS_RUN_CONTROL, 32'h00000000);
    rdc("mask reset", `OFS_IRQ_MASK, 32'h00000000);
    rdc("unmapped", 6'h34, 32'h00000000);
    bus(1'b0, `OFS_MODE_CONTROL, 32'hFFFFFFFF);
    rdc("mode bits", `OFS_MODE_CONTROL, 32'h0000FF7F);
    bus(1'b0, `OFS_MODE_CONTROL, 32'h00000000);
    $display("test registers done");
    bus(1'b0, `OFS_PERIOD, {16'h0000, P});
    bus(1'b0, `OFS_CMP_U, 32'h00000003);
    bus(1'b0, `OFS_CMP_V, 32'h00000005);
    bus(1'b0, `OFS_CMP_W, 32'h00000006);
    repeat (4) @(negedge ref_clk);
    check("u stopped", phase_u_level, 32'h00000003);
    check("v common", phase_v_level, 32'h00000003);
    check("gates on", gate, 32'h00000007);
    rdc("saw idle", `OFS_CARRIER_COUNT, 32'h00000001);
    bus(1'b0, `OFS_MODE_CONTROL, 32'h00000011);
    repeat (4) @(negedge ref_clk);
    check("v own", phase_v_level, 32'h00000005);
    check("w own", phase_w_level, 32'h00000006);
    rdc("tri idle", `OFS_CARRIER_COUNT, {16'h0000, P});
    $display("test stopped updates done");
    foreach (modes[i]) begin
      m = modes[i];
      egap = m[0] ? (P - 16'h0001) << m[2:1] : P;
      ecnt = (m[0] && !m[3]) ? 16'h0001 : P;
      bus(1'b0, `OFS_RUN_CONTROL, 32'h00000000);
      bus(1'b0, `OFS_MODE_CONTROL, {16'h0000, m});
      bus(1'b0, `OFS_RUN_CONTROL, 32'h00000001);
      wait_pulse();
      wait_pulse();
      check("irq gap", g, egap);
      if (!m[0] || m[2:1] != 2'h0) begin
        check("irq count", carrier_count, ecnt);
      end
    end
    $display("test carrier modes done");
    bus(1'b0, `OFS_RUN_CONTROL, 32'h00000000);
    bus(1'b0, `OFS_MODE_CONTROL, 32'h00000003);
    bus(1'b0, `OFS_RUN_CONTROL, 32'h00000001);
    wait_pulse();
    repeat (2) @(negedge ref_clk);
    check("irq masked", irq, 32'h00000000);
    bus(1'b0, `OFS_IRQ_MASK, 32'h00000001);
    repeat (2) @(negedge ref_clk);
    check("irq unmasked", irq, 32'h00000001);
    bus(1'b0, `OFS_RUN_CONTROL, 32'h00000000);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h00000000);
    check("status bit", q[0], 32'h00000001);
    repeat (3) @(negedge ref_clk);
    check("irq cleared", irq, 32'h00000000);
    $display("test interrupt done");
    bus(1'b0, `OFS_ENG_U, 32'h0000000A);
    bus(1'b0, `OFS_ENG_V, 32'h0000000C);
    bus(1'b0, `OFS_MODE_CONTROL, 32'h00002311);
    bus(1'b0, `OFS_RUN_CONTROL, 32'h00000007);
    wait_at(1'b0);
    check("u up", phase_u_level, 32'h00000003);
    check("v up", phase_v_level, 32'h0000000C);
    wait_at(1'b1);
    check("u down", phase_u_level, 32'h0000000A);
    bus(1'b0, `OFS_RUN_CONTROL, 32'h00000003);
    wait_at(1'b1);
    check("u no switch", phase_u_level, 32'h00000003);
    $display("test source switch done");
    bus(1'b0, `OFS_MODE_CONTROL, 32'h00000211);
    wait_at(1'b0);
    bus(1'b0, `OFS_CMP_U, 32'h00000004);
    wait_at(1'b1);
    repeat (3) @(negedge ref_clk);
    check("u not at bottom", phase_u_level, 32'h00000003);
    wait_at(1'b1);
    check("u at peak", phase_u_level, 32'h00000004);
    bus(1'b0, `OFS_MODE_CONTROL, 32'h00000011);
    wait_at(1'b0);
    bus(1'b0, `OFS_CMP_U, 32'h00000005);
    wait_at(1'b1);
    repeat (3) @(negedge ref_clk);
    check("u at bottom", phase_u_level, 32'h00000005);
    bus(1'b0, `OFS_RUN_CONTROL, 32'h00000000);
    bus(1'b0, `OFS_MODE_CONTROL, 32'h00000110);
    bus(1'b0, `OFS_RUN_CONTROL, 32'h00000001);
    wait_pulse();
    bus(1'b0, `OFS_CMP_U, 32'h00000006);
    wait_pulse();
    repeat (3) @(negedge ref_clk);
    check("u saw peak", phase_u_level, 32'h00000006);
    $display("test buffer timing done");
    final_report();
  end
endmodule // test_motor_pwm_carrier_control
